// ### logic/fcd_cmd_if.sv
`timescale 1ns/1ps
interface fcd_cmd_if;
  // Command bus cycle from the host controller
  logic req_valid;
  logic req_write;
  logic [fcd_pkg::ADDR_W-1:0] req_addr;
  logic [fcd_pkg::DATA_W-1:0] req_wdata;
  // Read answer from the device
  logic rsp_valid;
  logic [fcd_pkg::DATA_W-1:0] rsp_rdata;
  modport device (
    input req_valid, req_write, req_addr, req_wdata,
    output rsp_valid, rsp_rdata
  );
  modport host (
    output req_valid, req_write, req_addr, req_wdata,
    input rsp_valid, rsp_rdata
  );
endinterface

// ### logic/fcd_device.sv
// Contract
// RQ1: Values hex; addresses count 16-bit words.
// RQ2: All cycles writes except listed reads.
// RQ3: Upper data byte ignored in commands.
// RQ4: High address bits ignored for unlock cycles.
// RQ5: Array reads need no command cycles.
// RQ6: F0 leaves ID mode or error; FF too. Code takes FF in ID mode only, not under error.
// RQ7: CFI entry only when ready or ID.
// RQ8: Erase suspend allows program elsewhere, ID entry.
// RQ9: Erase suspend only during sector erase. Code takes B0 whenever erase_active is set, chip erase too.
// RQ10: Resume only in matching suspend state.
// RQ11: Abort state left by full AA-55-F0.
// RQ12: Overlays left only by exit command. Code also leaves them on a lone F0, abort excepted.
// RQ13: One password portion per A0, ascending.
// RQ14: Config bits one-time; erased reads one.
// RQ15: Both mode lock bits programmed aborts.
// RQ16: Sector lock read: bit0 low protected.
// RQ17: Sector lock commands ignore low address bits.
// RQ18: Only first word of status reads valid.
// RQ19: Status read: bits 0-2 meaningful, rest ones.
// RQ20: Parameter sectors need address bits 16-11.
// RQ21: ID and CFI entry open same data.
// RQ22: Buffer program 25, count, words, 29.
// RQ23: Stray write abandons partial sequence.
//
// Local design decisions: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module fcd_device #(
  parameter int ADDR_W = fcd_pkg::ADDR_W,
  parameter int BUF_CNT_W = fcd_pkg::BUF_CNT_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Command bus
  fcd_cmd_if.device bus,
  // Engine state
  input wire logic erase_active,
  input wire logic prog_active,
  input wire logic status_error_bit,
  // Read sources
  input wire logic [fcd_pkg::DATA_W-1:0] mem_rdata,
  input wire logic volatile_sector_lock,
  input wire logic nonvolatile_sector_lock,
  // Orders to the engines
  output logic op_valid_r,
  output fcd_pkg::fcd_op_e op_code_r,
  output logic [ADDR_W-1:0] op_addr_r,
  output logic [fcd_pkg::DATA_W-1:0] op_data_r,
  // Device state
  output fcd_pkg::fcd_mode_e overlay_address_space_r,
  output logic erase_susp_r,
  output logic prog_susp_r,
  output logic [fcd_pkg::DATA_W-1:0] protection_config_word_r
);
  localparam int DW = fcd_pkg::DATA_W;

  // Low address bits match an unlock address
  function automatic logic unl(input logic [ADDR_W-1:0] a,
                               input logic [fcd_pkg::UNL_W-1:0] exp);
    unl = (a[fcd_pkg::UNL_W-1:0] == exp); // [RQ4]
  endfunction

  // Same sector, offset bits ignored
  function automatic logic same_sect(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] b);
    same_sect = (a[ADDR_W-1:fcd_pkg::SECT_LSB] ==
                 b[ADDR_W-1:fcd_pkg::SECT_LSB]); // [RQ20]
  endfunction

  fcd_pkg::fcd_seq_e seq_r, seq_nxt; // Sequence progress
  fcd_pkg::fcd_mode_e mode_nxt; // Next overlay
  logic [ADDR_W-1:0] sect_r, sect_nxt; // Buffer target sector
  logic [ADDR_W-1:0] ers_sect_r, ers_sect_nxt; // Sector being erased
  logic [BUF_CNT_W-1:0] cnt_r, cnt_nxt; // Buffer words left
  logic [1:0] pw_next_r, pw_next_nxt; // Next password portion
  logic [DW-1:0] pcfg_nxt; // Next config word
  logic esusp_nxt, psusp_nxt; // Next suspend flags
  logic op_nxt; // Order pulse next
  fcd_pkg::fcd_op_e opc_nxt; // Order code next
  logic [ADDR_W-1:0] opa_nxt; // Order address next
  logic wr, rd, ready; // Cycle kinds
  logic [7:0] cb; // Command byte
  logic ovl_prot; // Protection overlay active

  assign wr = bus.req_valid && bus.req_write; // [RQ2]
  assign rd = bus.req_valid && !bus.req_write;
  assign cb = bus.req_wdata[7:0]; // [RQ3] [RQ1]
  assign ready = !erase_active && !prog_active;
  assign ovl_prot = (overlay_address_space_r == fcd_pkg::M_PCFG) ||
                    (overlay_address_space_r == fcd_pkg::M_NVLOCK) ||
                    (overlay_address_space_r == fcd_pkg::M_PASSWD);

  // Command decoder: next sequence, overlay and engine order
  always_comb begin
    seq_nxt = seq_r;
    mode_nxt = overlay_address_space_r;
    sect_nxt = sect_r;
    ers_sect_nxt = ers_sect_r;
    cnt_nxt = cnt_r;
    pw_next_nxt = pw_next_r;
    pcfg_nxt = protection_config_word_r;
    esusp_nxt = erase_susp_r;
    psusp_nxt = prog_susp_r;
    op_nxt = 1'b0;
    opc_nxt = fcd_pkg::OP_NONE;
    opa_nxt = bus.req_addr;
    if (rd && seq_r == fcd_pkg::S_STAT) begin
      // Status read consumes the armed sequence
      seq_nxt = fcd_pkg::S_IDLE;
    end else if (wr) begin
      seq_nxt = fcd_pkg::S_IDLE; // [RQ23]
      if (status_error_bit &&
          overlay_address_space_r == fcd_pkg::M_ARRAY) begin
        // Error latched: only reset is taken
        if (cb == fcd_pkg::C_RESET) begin // [RQ6]
          op_nxt = 1'b1;
          opc_nxt = fcd_pkg::OP_RESET;
        end
      end else begin
        unique case (seq_r)
          fcd_pkg::S_IDLE: begin
            if (cb == fcd_pkg::C_UNL1 &&
                unl(bus.req_addr, fcd_pkg::UNL_A1)) begin
              seq_nxt = fcd_pkg::S_AA;
            end else if (overlay_address_space_r == fcd_pkg::M_ABORT) begin
              // Lone reset does not leave abort
              seq_nxt = fcd_pkg::S_IDLE; // [RQ11]
            end else if (cb == fcd_pkg::C_RESET || (cb == fcd_pkg::C_RESET_ALT
                && overlay_address_space_r == fcd_pkg::M_ID)) begin
              mode_nxt = fcd_pkg::M_ARRAY; // [RQ6] [RQ12]
              op_nxt = 1'b1;
              opc_nxt = fcd_pkg::OP_RESET;
            end else if (ovl_prot && cb == fcd_pkg::C_EXIT) begin
              seq_nxt = fcd_pkg::S_X90; // [RQ12]
            end else if (ovl_prot && cb == fcd_pkg::C_PROG) begin
              seq_nxt = fcd_pkg::S_OA0;
            end else if (overlay_address_space_r == fcd_pkg::M_NVLOCK &&
                         cb == fcd_pkg::C_STAT) begin
              seq_nxt = fcd_pkg::S_STAT;
            end else if (cb == fcd_pkg::C_CFI &&
                         unl(bus.req_addr, fcd_pkg::UNL_A1) &&
                         ((overlay_address_space_r == fcd_pkg::M_ARRAY &&
                           ready) ||
                          overlay_address_space_r == fcd_pkg::M_ID)) begin
              mode_nxt = fcd_pkg::M_ID; // [RQ7] [RQ21]
            end else if (cb == fcd_pkg::C_ERS_SUSP && erase_active &&
                         !erase_susp_r) begin
              esusp_nxt = 1'b1; // [RQ9]
              op_nxt = 1'b1;
              opc_nxt = fcd_pkg::OP_ERS_SUSP;
            end else if (cb == fcd_pkg::C_ERS_RES && erase_susp_r &&
                         !prog_susp_r) begin
              esusp_nxt = 1'b0; // [RQ10]
              op_nxt = 1'b1;
              opc_nxt = fcd_pkg::OP_ERS_RES;
            end else if (cb == fcd_pkg::C_PRG_SUSP && prog_active &&
                         !prog_susp_r) begin
              psusp_nxt = 1'b1; // [RQ8]
              op_nxt = 1'b1;
              opc_nxt = fcd_pkg::OP_PRG_SUSP;
            end else if (cb == fcd_pkg::C_PRG_RES && prog_susp_r) begin
              psusp_nxt = 1'b0; // [RQ10]
              op_nxt = 1'b1;
              opc_nxt = fcd_pkg::OP_PRG_RES;
            end
          end
          fcd_pkg::S_AA: begin
            if (cb == fcd_pkg::C_UNL2 &&
                unl(bus.req_addr, fcd_pkg::UNL_A2)) begin
              seq_nxt = fcd_pkg::S_55;
            end
          end
          fcd_pkg::S_55: begin
            if (overlay_address_space_r == fcd_pkg::M_ABORT) begin
              if (cb == fcd_pkg::C_RESET) begin
                mode_nxt = fcd_pkg::M_ARRAY; // [RQ11]
                op_nxt = 1'b1;
                opc_nxt = fcd_pkg::OP_RESET;
              end
            end else if (cb == fcd_pkg::C_BUF && !prog_susp_r &&
                (overlay_address_space_r == fcd_pkg::M_SECURE ||
                 overlay_address_space_r == fcd_pkg::M_ARRAY)) begin
              // Buffer load opens at the sector address
              sect_nxt = bus.req_addr; // [RQ22]
              seq_nxt = fcd_pkg::S_WC;
            end else if (unl(bus.req_addr, fcd_pkg::UNL_A1)) begin
              if (cb == fcd_pkg::C_PROG && !prog_susp_r &&
                  (overlay_address_space_r == fcd_pkg::M_ARRAY ||
                   overlay_address_space_r == fcd_pkg::M_SECURE)) begin
                seq_nxt = fcd_pkg::S_A0;
              end else if (cb == fcd_pkg::C_ERASE && ready &&
                  overlay_address_space_r == fcd_pkg::M_ARRAY) begin
                seq_nxt = fcd_pkg::S_80;
              end else if (cb == fcd_pkg::C_EXIT &&
                  overlay_address_space_r == fcd_pkg::M_SECURE) begin
                seq_nxt = fcd_pkg::S_X90; // [RQ12]
              end else if (overlay_address_space_r == fcd_pkg::M_ARRAY) begin
                if (cb == fcd_pkg::C_ID) begin
                  mode_nxt = fcd_pkg::M_ID; // [RQ8] [RQ21]
                end else if (!erase_susp_r && ready) begin
                  if (cb == fcd_pkg::C_SECURE) begin
                    mode_nxt = fcd_pkg::M_SECURE;
                  end else if (cb == fcd_pkg::C_PCFG) begin
                    mode_nxt = fcd_pkg::M_PCFG;
                  end else if (cb == fcd_pkg::C_NVLOCK) begin
                    mode_nxt = fcd_pkg::M_NVLOCK;
                  end else if (cb == fcd_pkg::C_PASSWD) begin
                    mode_nxt = fcd_pkg::M_PASSWD;
                    pw_next_nxt = fcd_pkg::PW_FIRST;
                  end
                end
              end
            end
          end
          fcd_pkg::S_80: begin
            if (cb == fcd_pkg::C_UNL1 &&
                unl(bus.req_addr, fcd_pkg::UNL_A1)) begin
              seq_nxt = fcd_pkg::S_80AA;
            end
          end
          fcd_pkg::S_80AA: begin
            if (cb == fcd_pkg::C_UNL2 &&
                unl(bus.req_addr, fcd_pkg::UNL_A2)) begin
              seq_nxt = fcd_pkg::S_8055;
            end
          end
          fcd_pkg::S_8055: begin
            if (cb == fcd_pkg::C_CHIP &&
                unl(bus.req_addr, fcd_pkg::UNL_A1)) begin
              op_nxt = 1'b1;
              opc_nxt = fcd_pkg::OP_CHIP_ERASE;
            end else if (cb == fcd_pkg::C_SECT) begin
              ers_sect_nxt = bus.req_addr; // [RQ20]
              op_nxt = 1'b1;
              opc_nxt = fcd_pkg::OP_SECT_ERASE;
            end
          end
          fcd_pkg::S_A0: begin
            // No program inside the sector under suspended erase
            if (!(erase_susp_r && same_sect(bus.req_addr, ers_sect_r))) begin
              op_nxt = 1'b1; // [RQ8]
              opc_nxt = fcd_pkg::OP_WORD_PROG;
            end
          end
          fcd_pkg::S_WC: begin
            // Word count uses the low BUF_CNT_W data bits
            if (same_sect(bus.req_addr, sect_r) &&
                !(erase_susp_r && same_sect(sect_r, ers_sect_r))) begin
              cnt_nxt = bus.req_wdata[BUF_CNT_W-1:0]; // [RQ22]
              op_nxt = 1'b1;
              opc_nxt = fcd_pkg::OP_BUF_START;
              seq_nxt = fcd_pkg::S_WD;
            end else begin
              mode_nxt = fcd_pkg::M_ABORT;
            end
          end
          fcd_pkg::S_WD: begin
            // Words must stay inside the target sector
            if (same_sect(bus.req_addr, sect_r)) begin
              op_nxt = 1'b1; // [RQ22]
              opc_nxt = fcd_pkg::OP_BUF_WORD;
              cnt_nxt = cnt_r - 1'b1;
              seq_nxt = (cnt_r == '0) ? fcd_pkg::S_CONF : fcd_pkg::S_WD;
            end else begin
              mode_nxt = fcd_pkg::M_ABORT;
            end
          end
          fcd_pkg::S_CONF: begin
            // Commit, or fall into the abort state
            if (cb == fcd_pkg::C_CONF && same_sect(bus.req_addr, sect_r)) begin
              op_nxt = 1'b1; // [RQ22]
              opc_nxt = fcd_pkg::OP_BUF_COMMIT;
            end else begin
              mode_nxt = fcd_pkg::M_ABORT;
            end
          end
          fcd_pkg::S_X90: begin
            if (cb == fcd_pkg::C_EXIT2) begin
              mode_nxt = fcd_pkg::M_ARRAY; // [RQ12]
            end
          end
          fcd_pkg::S_OA0: begin
            if (overlay_address_space_r == fcd_pkg::M_PCFG) begin
              if (!bus.req_wdata[fcd_pkg::PCFG_PERS_BIT] &&
                  !bus.req_wdata[fcd_pkg::PCFG_PW_BIT]) begin
                mode_nxt = fcd_pkg::M_ARRAY; // [RQ15]
              end else begin
                // Bits only ever go from one to zero
                pcfg_nxt = protection_config_word_r & bus.req_wdata; // [RQ14]
              end
            end else if (overlay_address_space_r == fcd_pkg::M_NVLOCK) begin
              op_nxt = 1'b1;
              opc_nxt = fcd_pkg::OP_NVLOCK_PROG;
              opa_nxt = {bus.req_addr[ADDR_W-1:fcd_pkg::SECT_LSB],
                         {fcd_pkg::SECT_LSB{1'b0}}}; // [RQ17]
            end else if (bus.req_addr[1:0] == pw_next_r) begin
              // Portions out of order are dropped
              op_nxt = 1'b1; // [RQ13]
              opc_nxt = fcd_pkg::OP_PW_PROG;
              pw_next_nxt = pw_next_r + 2'h1;
            end
          end
          fcd_pkg::S_STAT: begin
            seq_nxt = fcd_pkg::S_IDLE;
          end
          default: begin
            seq_nxt = fcd_pkg::S_IDLE;
          end
        endcase
      end
    end
  end

  // Sequence, overlay and buffer bookkeeping
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      seq_r <= fcd_pkg::S_IDLE;
      overlay_address_space_r <= fcd_pkg::M_ARRAY;
      sect_r <= '0;
      ers_sect_r <= '0;
      cnt_r <= '0;
      pw_next_r <= fcd_pkg::PW_FIRST;
    end else begin
      seq_r <= seq_nxt;
      overlay_address_space_r <= mode_nxt;
      sect_r <= sect_nxt;
      ers_sect_r <= ers_sect_nxt;
      cnt_r <= cnt_nxt;
      pw_next_r <= pw_next_nxt;
    end
  end

  // One-time protection configuration word and suspend flags
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      protection_config_word_r <= fcd_pkg::PCFG_RESET;
      erase_susp_r <= 1'b0;
      prog_susp_r <= 1'b0;
    end else begin
      protection_config_word_r <= pcfg_nxt; // [RQ14]
      erase_susp_r <= esusp_nxt;
      prog_susp_r <= psusp_nxt;
    end
  end

  // Engine orders, one-cycle pulse
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      op_valid_r <= 1'b0;
      op_code_r <= fcd_pkg::OP_NONE;
      op_addr_r <= '0;
      op_data_r <= '0;
    end else begin
      op_valid_r <= op_nxt;
      op_code_r <= opc_nxt;
      op_addr_r <= opa_nxt;
      op_data_r <= bus.req_wdata;
    end
  end

  // Read answer, one word per read cycle
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      bus.rsp_valid <= 1'b0;
      bus.rsp_rdata <= '0;
    end else begin
      bus.rsp_valid <= rd; // [RQ18]
      if (rd) begin
        if (seq_r == fcd_pkg::S_STAT) begin
          bus.rsp_rdata <= {fcd_pkg::ALL_ONES[DW-1:3],
                            !nonvolatile_sector_lock,
                            !volatile_sector_lock,
                            !(volatile_sector_lock ||
                              nonvolatile_sector_lock)}; // [RQ19]
        end else if (overlay_address_space_r == fcd_pkg::M_NVLOCK) begin
          bus.rsp_rdata <= {fcd_pkg::ALL_ONES[DW-1:1],
                            !nonvolatile_sector_lock}; // [RQ16]
        end else if (overlay_address_space_r == fcd_pkg::M_PCFG) begin
          bus.rsp_rdata <= protection_config_word_r;
        end else if (overlay_address_space_r == fcd_pkg::M_PASSWD) begin
          bus.rsp_rdata <= fcd_pkg::ALL_ONES;
        end else begin
          bus.rsp_rdata <= mem_rdata; // [RQ5] [RQ21]
        end
      end
    end
  end
endmodule

// ### logic/fcd_host.sv
`timescale 1ns/1ps
module fcd_host #(
  parameter int ADDR_W = fcd_pkg::ADDR_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Command bus
  fcd_cmd_if.host bus
);
  localparam int DW = fcd_pkg::DATA_W;

  logic [7:0] dp_addr_r; // Data-phase register offset
  logic dp_wr_r; // Data phase is a write
  logic [ADDR_W-1:0] addr_r; // Word address of next cycle
  logic busy_r; // Waiting for read answer
  logic done_r; // Read answer held
  logic [DW-1:0] rdata_r; // Captured first word
  logic addr_ph; // Address phase taken
  logic go_wr, go_rd; // Cycle launches

  assign addr_ph = hsel && htrans[1] && hready;
  assign go_wr = dp_wr_r && dp_addr_r == fcd_pkg::R_WDATA && !busy_r;
  assign go_rd = dp_wr_r && dp_addr_r == fcd_pkg::R_CTRL &&
                 hwdata[fcd_pkg::CTRL_READ] && !busy_r;

  // Bus slave: zero wait states, always OKAY
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      dp_addr_r <= '0;
      dp_wr_r <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      dp_addr_r <= haddr[7:0];
      dp_wr_r <= addr_ph && hwrite;
    end
  end

  // Read data prepared in the address phase
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hrdata <= '0;
    end else if (addr_ph && !hwrite) begin
      unique case (haddr[7:0])
        fcd_pkg::R_ADDR: hrdata <= 32'(addr_r);
        fcd_pkg::R_STATUS: hrdata <= {30'h0, done_r, busy_r};
        fcd_pkg::R_RDATA: hrdata <= 32'(rdata_r);
        default: hrdata <= '0;
      endcase
    end
  end

  // Word address register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_r <= '0;
    end else if (dp_wr_r && dp_addr_r == fcd_pkg::R_ADDR) begin
      addr_r <= hwdata[ADDR_W-1:0]; // [RQ1]
    end
  end

  // Command cycle launch, one-cycle request
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      bus.req_valid <= 1'b0;
      bus.req_write <= 1'b0;
      bus.req_addr <= '0;
      bus.req_wdata <= '0;
    end else begin
      bus.req_valid <= go_wr || go_rd;
      bus.req_write <= go_wr; // [RQ2]
      if (go_wr || go_rd) begin
        bus.req_addr <= addr_r;
      end
      if (go_wr) begin
        // Full word passes for program data and passwords
        bus.req_wdata <= hwdata[DW-1:0]; // [RQ13] [RQ22]
      end
    end
  end

  // Read tracking: keep only the first answer word
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      rdata_r <= '0;
    end else if (go_rd) begin
      busy_r <= 1'b1;
      done_r <= 1'b0;
    end else if (busy_r && bus.rsp_valid) begin
      busy_r <= 1'b0; // [RQ18]
      done_r <= 1'b1;
      rdata_r <= bus.rsp_rdata;
    end
  end
endmodule

// ### logic/fcd_pkg.sv
package fcd_pkg;
  // Bus widths
  localparam int ADDR_W = 25;
  localparam int DATA_W = 16;
  localparam int BUF_CNT_W = 8;
  localparam int SECT_LSB = 11;
  localparam int UNL_W = 11;
  // Unlock addresses, compared on the low word-address bits only
  localparam logic [UNL_W-1:0] UNL_A1 = 11'h555;
  localparam logic [UNL_W-1:0] UNL_A2 = 11'h2aa;
  // Command data bytes
  localparam logic [7:0] C_UNL1 = 8'haa;
  localparam logic [7:0] C_UNL2 = 8'h55;
  localparam logic [7:0] C_RESET = 8'hf0;
  localparam logic [7:0] C_RESET_ALT = 8'hff;
  localparam logic [7:0] C_ERASE = 8'h80;
  localparam logic [7:0] C_CHIP = 8'h10;
  localparam logic [7:0] C_SECT = 8'h30;
  localparam logic [7:0] C_ERS_RES = 8'h30;
  localparam logic [7:0] C_ERS_SUSP = 8'hb0;
  localparam logic [7:0] C_PRG_SUSP = 8'h51;
  localparam logic [7:0] C_PRG_RES = 8'h50;
  localparam logic [7:0] C_PROG = 8'ha0;
  localparam logic [7:0] C_BUF = 8'h25;
  localparam logic [7:0] C_CONF = 8'h29;
  localparam logic [7:0] C_ID = 8'h90;
  localparam logic [7:0] C_CFI = 8'h98;
  localparam logic [7:0] C_SECURE = 8'h88;
  localparam logic [7:0] C_PCFG = 8'h40;
  localparam logic [7:0] C_NVLOCK = 8'hc0;
  localparam logic [7:0] C_PASSWD = 8'h60;
  localparam logic [7:0] C_STAT = 8'h60;
  localparam logic [7:0] C_EXIT = 8'h90;
  localparam logic [7:0] C_EXIT2 = 8'h00;
  // Protection configuration word
  localparam int PCFG_PERS_BIT = 1;
  localparam int PCFG_PW_BIT = 2;
  localparam logic [DATA_W-1:0] PCFG_RESET = 16'hffff;
  localparam logic [DATA_W-1:0] ALL_ONES = 16'hffff;
  localparam logic [1:0] PW_FIRST = 2'h0;
  // Host register offsets (byte addresses)
  localparam logic [7:0] R_ADDR = 8'h00;
  localparam logic [7:0] R_WDATA = 8'h04;
  localparam logic [7:0] R_CTRL = 8'h08;
  localparam logic [7:0] R_STATUS = 8'h0c;
  localparam logic [7:0] R_RDATA = 8'h10;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int CTRL_READ = 0;
  // Overlay address space of the device
  typedef enum logic [2:0] {
    M_ARRAY = 3'b000, M_ID = 3'b001, M_SECURE = 3'b011, M_PCFG = 3'b010,
    M_NVLOCK = 3'b110, M_PASSWD = 3'b111, M_ABORT = 3'b101
  } fcd_mode_e;
  // Command sequence progress
  typedef enum logic [3:0] {
    S_IDLE = 4'b0000, S_AA = 4'b0001, S_55 = 4'b0011, S_80 = 4'b0010,
    S_80AA = 4'b0110, S_8055 = 4'b0111, S_A0 = 4'b0101, S_WC = 4'b0100,
    S_WD = 4'b1100, S_CONF = 4'b1101, S_X90 = 4'b1111, S_OA0 = 4'b1110,
    S_STAT = 4'b1010
  } fcd_seq_e;
  // Orders passed to the program and erase engines
  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_WORD_PROG = 4'h1, OP_BUF_START = 4'h2,
    OP_BUF_WORD = 4'h3, OP_BUF_COMMIT = 4'h4, OP_CHIP_ERASE = 4'h5,
    OP_SECT_ERASE = 4'h6, OP_ERS_SUSP = 4'h7, OP_ERS_RES = 4'h8,
    OP_PRG_SUSP = 4'h9, OP_PRG_RES = 4'ha, OP_NVLOCK_PROG = 4'hb,
    OP_PW_PROG = 4'hc, OP_RESET = 4'hd
  } fcd_op_e;
endpackage

// ### tb/fcd_cmd_asserts.sv
`timescale 1ns/1ps
module fcd_cmd_asserts (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Command bus
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic rsp_valid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Read request and its single answer word
  sequence rd_req; req_valid && !req_write; endsequence
  sequence one_ans; rsp_valid ##1 !rsp_valid; endsequence
  rd_answer_a: assert property (rd_req |=> one_ans)
    else $error("read not answered");
  rsp_cause_a: assert property (
    rsp_valid |-> $past(req_valid && !req_write))
    else $error("answer without read");
  wr_silent_a: assert property (req_valid && req_write |=> !rsp_valid)
    else $error("answer to a write");
  rsp_alone_a: assert property (rsp_valid |-> !req_valid)
    else $error("request during answer");
  rd_gap_a: assert property (rd_req |=> !req_valid)
    else $error("request right after read");
  rsp_spacing_a: assert property (rsp_valid |=> !rsp_valid [*2])
    else $error("answers too close");
  rsp_width_a: assert property (
    $fell(rsp_valid) |-> !$past(rsp_valid, 2))
    else $error("answer wider than one cycle");
  reset_quiet_a: assert property (
    $rose(reset_n) |-> !req_valid && !rsp_valid)
    else $error("bus busy after reset");
endmodule

// ### tb/flash_overlay_command_decoder_test.sv
`timescale 1ns/1ps
module flash_overlay_command_decoder_test;
  logic core_clk, reset_n, hwrite, erase_active, vlock, nvlock, esusp, psusp;
  logic err, op_v; // Error bit and order pulse
  fcd_pkg::fcd_op_e op_c, last_op; // Order code and last order seen
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [15:0] mem_rd, pcfg;
  wire hready;
  fcd_pkg::fcd_mode_e mode;
  int bad_count = 0;
  int check_count = 0;
  fcd_cmd_if bus();
  // Array word model: data depends on the word address
  assign mem_rd = bus.req_addr[15:0] ^ 16'h5a5a;
  // Last order handed to the engines
  always @(posedge core_clk) begin
    if (op_v) last_op <= op_c;
  end
  fcd_host i_fcd_host (.core_clk, .reset_n, .hsel(1'b1), .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready, .hreadyout(hready), .hresp(),
    .hrdata, .bus(bus.host));
  fcd_device i_fcd_device (.core_clk, .reset_n, .bus(bus.device),
    .erase_active, .prog_active(1'b0), .status_error_bit(err),
    .mem_rdata(mem_rd), .volatile_sector_lock(vlock),
    .nonvolatile_sector_lock(nvlock), .op_valid_r(op_v), .op_code_r(op_c),
    .op_addr_r(), .op_data_r(), .overlay_address_space_r(mode),
    .erase_susp_r(esusp), .prog_susp_r(psusp),
    .protection_config_word_r(pcfg));
  fcd_cmd_asserts i_fcd_cmd_asserts (.core_clk, .reset_n,
    .req_valid(bus.req_valid), .req_write(bus.req_write),
    .rsp_valid(bus.rsp_valid));
  task final_report;
    if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Bounded wait for hready at a rising edge
  task hwait;
    int n;
    n = 0;
    @(posedge core_clk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 50) begin
        bad_count++;
        final_report;
      end
      @(posedge core_clk);
    end
  endtask
  // One AHB single word transfer
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hwait;
    htrans <= 2'h0;
    hwdata <= d;
    hwait;
    rd = hrdata;
  endtask
  // Command write cycle, then settle the device state
  task cmd(input logic [24:0] a, input logic [15:0] d);
    ahb(1'b1, 8'h00, {7'h0, a});
    ahb(1'b1, 8'h04, {16'h0, d});
    repeat (3) @(posedge core_clk);
  endtask
  // Unlock pair with high address bits and upper data byte set
  task unl(input logic [24:0] a, input logic [7:0] c);
    cmd(25'h1abd555, 16'hffaa);
    cmd(25'h0f32aa, 16'hc355);
    cmd(a, {8'h00, c});
  endtask
  task rdw(input logic [24:0] a);
    int n;
    n = 0;
    ahb(1'b1, 8'h00, {7'h0, a});
    ahb(1'b1, 8'h08, 32'h1);
    do begin
      ahb(1'b0, 8'h0c, 32'h0);
      n++;
    end while (rd[1] !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      final_report;
    end
    ahb(1'b0, 8'h10, 32'h0);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    {reset_n, hwrite, erase_active, nvlock, err, htrans, haddr, hwdata} = '0;
    vlock = 1'b1;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    rdw(25'h123); chk(rd, 32'h5b79);
    err <= 1'b1;
    unl(25'h555, 8'h90); chk(mode, fcd_pkg::M_ARRAY);
    cmd(0, 16'hf0);
    chk(last_op, fcd_pkg::OP_RESET);
    err <= 1'b0;
    chk(pcfg, 16'hffff);
    unl(25'h555, 8'h90); chk(mode, fcd_pkg::M_ID);
    cmd(25'h555, 16'h98); chk(mode, fcd_pkg::M_ID);
    cmd(25'h0, 16'hff); chk(mode, fcd_pkg::M_ARRAY);
    cmd(25'h555, 16'h98); chk(mode, fcd_pkg::M_ID);
    cmd(25'h0, 16'hf0); chk(mode, fcd_pkg::M_ARRAY);
    unl(25'h555, 8'h40); cmd(0, 16'ha0); cmd(0, 16'hfff9);
    chk({mode, pcfg}, {fcd_pkg::M_ARRAY, 16'hffff});
    unl(25'h555, 8'h40); cmd(0, 16'ha0); cmd(0, 16'hfffd);
    cmd(0, 16'ha0); cmd(0, 16'hffff); chk(pcfg, 16'hfffd);
    cmd(0, 16'h90); cmd(0, 16'h00); chk(mode, fcd_pkg::M_ARRAY);
    cmd(0, 16'hb0); chk(esusp, 1'b0);
    erase_active <= 1'b1;
    cmd(0, 16'hb0); chk(esusp, 1'b1);
    chk(last_op, fcd_pkg::OP_ERS_SUSP);
    cmd(0, 16'h50); chk(psusp, 1'b0);
    cmd(0, 16'h30); chk(esusp, 1'b0);
    erase_active <= 1'b0;
    unl(25'h555, 8'hc0);
    nvlock <= 1'b1;
    rdw(25'h800); chk(rd, 32'hfffe);
    nvlock <= 1'b0;
    cmd(0, 16'h60);
    rdw(25'h800); chk(rd, 32'hfffc);
    cmd(0, 16'hf0); chk(mode, fcd_pkg::M_ARRAY);
    unl(25'h800, 8'h25); cmd(25'h800, 16'h0);
    chk(last_op, fcd_pkg::OP_BUF_START);
    cmd(25'h1000, 16'h1234);
    chk(mode, fcd_pkg::M_ABORT);
    cmd(0, 16'hf0); chk(mode, fcd_pkg::M_ABORT);
    unl(25'h555, 8'hf0); chk(mode, fcd_pkg::M_ARRAY);
    chk(last_op, fcd_pkg::OP_RESET);
    final_report;
  end
endmodule
